/* File: design/psbp_device.sv */
/*
  Device end: serial receiver, request checker, command execution and response builder.
  Response bytes pass through a 16-word FIFO into the serial transmitter.
  Assumes the host waits for the reply before the next request (half-duplex bus).
*/
`timescale 1ns/1ps
module psbp_device (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link
  psbp_link_if.device link,
  // serial configuration
  input wire logic [15:0] baudDiv,
  input wire psbp_pkg::psbp_fmt_t charFmt,
  input wire logic [3:0] stationAddr,
  // measurement and status inputs
  input wire logic [31:0] measured_value,
  input wire logic [31:0] speedLong,
  input wire logic [15:0] speed_value,
  input wire logic [23:0] markerCode,
  input wire logic markerValid,
  input wire logic [23:0] diagCode,
  input wire logic diagValid,
  input wire logic tape_orientation,
  input wire logic deviceReady,
  input wire logic switch_line_one,
  input wire logic switch_line_two,
  input wire logic temp_warning,
  input wire logic [6:0] qualityPercent,
  input wire logic measureInvalid,
  input wire logic deviceError,
  // control outputs
  output logic positioning,
  output logic sleepActive,
  output logic reqDropped
);
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_PAR = 2'b10,
    RX_STOP = 2'b11
  } psbp_rx_t;

  // receiver
  psbp_rx_t rxSt_q;
  logic rxS1_q, rxS2_q;
  logic [15:0] rxCnt_q;
  logic [2:0] rxBit_q;
  logic [7:0] rxSh_q;
  logic rxPar_q;
  logic [1:0] reqIdx_q;
  logic [7:0] hdr_q, cmd_q;
  logic rxDone;
  logic txEnN_q;
  logic [16:0] quiet_q;
  wire rxMid = rxCnt_q == {1'b0, baudDiv[15:1]};
  wire rxEnd = rxCnt_q == baudDiv - 16'h0001; // R22
  wire hasPar = charFmt == psbp_pkg::FMT_8E1 || charFmt == psbp_pkg::FMT_8O1;
  wire parOk = !hasPar || ((psbp_pkg::parity8(rxSh_q) ^ rxPar_q) == (charFmt == psbp_pkg::FMT_8O1));
  // replies wait two idle bit times: the host may still be sending a second stop bit
  wire quiet = quiet_q >= {baudDiv, 1'b0};

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
      rxSt_q <= RX_IDLE;
      rxCnt_q <= 16'h0000;
      rxBit_q <= 3'h0;
      rxSh_q <= 8'h00;
      rxPar_q <= 1'b0;
      quiet_q <= 17'h0_0000;
    end else begin
      rxS1_q <= link.busLine;
      rxS2_q <= rxS1_q;
      quiet_q <= (rxS2_q && rxSt_q == RX_IDLE) ? quiet_q + 17'(!quiet) : 17'h0_0000;
      rxCnt_q <= (rxEnd || rxSt_q == RX_IDLE) ? 16'h0000 : rxCnt_q + 16'h0001;
      unique case (rxSt_q)
        RX_IDLE: begin
          if (!rxS2_q && txEnN_q) begin // own reply echoes on the line
            rxSt_q <= RX_DATA;
            rxBit_q <= 3'h0;
            rxCnt_q <= 16'h0000 - baudDiv;
          end
        end
        RX_DATA: begin // R21
          if (rxMid) begin
            rxSh_q <= {rxS2_q, rxSh_q[7:1]};
          end
          if (rxEnd) begin
            rxBit_q <= rxBit_q + 3'h1;
            if (rxBit_q == 3'h7) begin
              rxSt_q <= rxBit_q == 3'h7 && !hasPar ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (rxMid) begin
            rxPar_q <= rxS2_q;
          end
          if (rxEnd) begin
            rxSt_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          // back to idle at mid-stop so the next start edge is caught
          if (rxMid) begin
            rxSt_q <= RX_IDLE;
          end
        end
      endcase
    end
  end
  // counter preloaded a bit time early: first mid-point lands in data bit 0
  assign rxDone = rxSt_q == RX_STOP && rxMid && rxS2_q && parOk;

  // request assembly and check
  wire [7:0] rxByte = rxSh_q;
  wire reqFull = rxDone && reqIdx_q == 2'd2; // R01
  wire hdrOk = hdr_q[7:psbp_pkg::HdrPatternLsb] == psbp_pkg::HdrPattern; // R24
  wire addrOk = hdr_q[3:0] == stationAddr; // R23
  wire sumOk = rxByte == (hdr_q ^ cmd_q); // R08
  wire cmdOk = psbp_pkg::known_cmd(cmd_q); // R24
  wire reqAccept = reqFull && hdrOk && addrOk && sumOk && cmdOk;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reqIdx_q <= 2'd0;
      hdr_q <= 8'h00;
      cmd_q <= 8'h00;
      reqDropped <= 1'b0;
    end else begin
      reqDropped <= reqFull && !reqAccept;
      if (rxDone) begin
        unique case (reqIdx_q)
          2'd0: hdr_q <= rxByte;
          2'd1: cmd_q <= rxByte;
          default: ;
        endcase
        reqIdx_q <= (reqIdx_q == 2'd2) ? 2'd0 : reqIdx_q + 2'd1;
      end
    end
  end

  // command effects
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      positioning <= 1'b0;
      sleepActive <= 1'b0;
    end else if (reqAccept) begin
      if (cmd_q == psbp_pkg::CmdStart) begin // R05
        positioning <= 1'b1;
        sleepActive <= 1'b0;
      end
      if (cmd_q == psbp_pkg::CmdStop) begin // R05
        positioning <= 1'b0;
      end
      if (cmd_q == psbp_pkg::CmdSleep) begin // R05
        positioning <= 1'b0;
        sleepActive <= 1'b1;
      end
    end
  end

  // response build
  wire [1:0] quality = qualityPercent >= 7'd75 ? psbp_pkg::QualAbove75 :
                       qualityPercent >= 7'd50 ? psbp_pkg::Qual50To74 :
                       qualityPercent >= 7'd25 ? psbp_pkg::Qual25To49 : psbp_pkg::QualBelow25; // R18
  wire [7:0] stat0 = {tape_orientation, deviceReady, switch_line_two, switch_line_one, stationAddr}; // R15 R16
  wire [7:0] stat1 = {temp_warning, quality, sleepActive, markerValid, diagValid,
                      measureInvalid, deviceError}; // R17 R19
  wire [23:0] diagText = diagValid ? diagCode : psbp_pkg::DiagNone; // R14
  logic [31:0] payload;
  always_comb begin
    unique case (cmd_q)
      psbp_pkg::CmdSpeed: payload = speedLong; // R04
      psbp_pkg::CmdMarker: payload = {8'h00, markerCode}; // R06 R13
      psbp_pkg::CmdDiag: payload = {8'h00, diagText}; // R06 R13
      default: payload = measured_value; // R04 R11
    endcase
  end
  wire isLong = cmd_q == psbp_pkg::CmdPosSpeed; // R10
  wire isData = cmd_q != psbp_pkg::CmdStart && cmd_q != psbp_pkg::CmdStop && cmd_q != psbp_pkg::CmdSleep;
  wire [71:0] longMsg = {stat0, stat1, measured_value, speed_value, 8'h00}; // R12
  wire [71:0] shortMsg = {stat0, stat1, payload, 8'h00, 16'h0000}; // R09

  // response serialiser into the FIFO
  logic [71:0] msg_q;
  logic [3:0] left_q;
  logic [7:0] xor_q;
  logic fInValid, fInReady, fOutValid, fOutReady;
  logic [7:0] fInData, fOutData;
  wire lastByte = left_q == 4'h1;
  assign fInValid = left_q != 4'h0;
  assign fInData = lastByte ? xor_q : msg_q[71:64]; // R20

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      msg_q <= 72'h0;
      left_q <= 4'h0;
      xor_q <= 8'h00;
    end else if (left_q == 4'h0) begin
      // command F4/F5/FD: executed without any reply
      if (reqAccept && isData) begin
        msg_q <= isLong ? longMsg : shortMsg;
        left_q <= isLong ? psbp_pkg::RespLongLen : psbp_pkg::RespShortLen; // R01
        xor_q <= 8'h00;
      end
    end else if (fInReady) begin
      msg_q <= {msg_q[63:0], 8'h00};
      left_q <= left_q - 4'h1;
      xor_q <= xor_q ^ msg_q[71:64]; // R20
    end
  end

  psbp_fifo #(.Width(psbp_pkg::FifoWidth), .Depth(psbp_pkg::FifoDepth)) txFifo (
    .mclk(mclk),
    .resetn(resetn),
    .inValid(fInValid),
    .inReady(fInReady),
    .inData(fInData),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData)
  );

  // transmitter: start, 8 data lsb first, optional parity, one or two stops
  logic [10:0] txSh_q;
  logic [3:0] txLeft_q;
  logic [15:0] txCnt_q;
  logic txOut_q;
  wire txPar = psbp_pkg::parity8(fOutData) ^ (charFmt == psbp_pkg::FMT_8O1);
  wire [10:0] txFrame = hasPar ? {1'b1, txPar, fOutData, 1'b0} : {2'b11, fOutData, 1'b0};
  wire [3:0] txBits = charFmt == psbp_pkg::FMT_8N1 ? 4'd10 : 4'd11;
  assign fOutReady = txLeft_q == 4'h0 && (!txEnN_q || quiet);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txSh_q <= 11'h7FF;
      txLeft_q <= 4'h0;
      txCnt_q <= 16'h0000;
      txOut_q <= 1'b1;
      txEnN_q <= 1'b1;
    end else if (txLeft_q == 4'h0) begin
      txOut_q <= 1'b1;
      txEnN_q <= !(fOutValid && fOutReady); // bus released between replies
      if (fOutValid && fOutReady) begin
        txSh_q <= txFrame;
        txLeft_q <= txBits;
        txCnt_q <= 16'h0000;
      end
    end else begin
      txOut_q <= txSh_q[0];
      txEnN_q <= 1'b0;
      if (txCnt_q == baudDiv - 16'h0001) begin
        txCnt_q <= 16'h0000;
        txSh_q <= {1'b1, txSh_q[10:1]};
        txLeft_q <= txLeft_q - 4'h1;
      end else begin
        txCnt_q <= txCnt_q + 16'h0001;
      end
    end
  end
  assign link.devTx = txOut_q;
  assign link.devTxEnN = txEnN_q;
endmodule

/* File: design/psbp_pkg.sv */
/*
  Shared constants and types for the position-sensor binary request/response protocol: telegram layout,
  command codes, status-bit positions, serial character timing and diagnostic codes.
  Assumes one 125 MHz clock (mclk) and a synchronous active-low reset at both ends.
*/
//
// Behaviour
// R01: request three bytes, response seven or nine
// R02: request header top bits 11, bits 5:4 00
// R03: four-bit station address in header bits 3:0
// R04: F1 position, F6 speed, F8 both
// R05: F4 start, F5 stop, FD standby
// R06: FA marker code, FC diagnostic code
// R07: request check byte is XOR of bytes 0,1
// R08: bad request check byte: discard, no answer
// R09: seven-byte reply: status, four data, check
// R10: F8 reply: status, position, speed, check
// R11: bytes 2-5 value, most significant first
// R12: bytes 6-7 speed, high byte first
// R13: FA/FC: byte 2 zero, three ASCII bytes
// R14: diagnostic codes E00 to E05, E00 initial
// R15: byte 0: orientation, ready, address bits
// R16: byte 0 bits 5,4: switch lines two, one
// R17: byte 1 bit 7: temperature out of range
// R18: two-bit reading quality field by percentage
// R19: byte 1: sleep, marker, stored_a, invalid, error
// R20: response check byte XOR of all bytes
// R21: eight data bits, parity/stop format selectable
// R22: 4800 to 115200 baud, default 38400
// R23: ignore requests for other station addresses
// R24: ignore bad header or unknown command
package psbp_pkg;

  // clock and serial timing
  localparam int ClkHz = 125_000_000;
  localparam int BaudMin = 4_800;
  localparam int BaudMax = 115_200;
  localparam int BaudDefault = 38_400;
  localparam logic [15:0] BaudDivDefault = 16'(ClkHz / BaudDefault);
  localparam logic [15:0] BaudDivMin = 16'(ClkHz / BaudMax);
  localparam logic [15:0] BaudDivMax = 16'(ClkHz / BaudMin);

  // character formats
  typedef enum logic [1:0] {
    FMT_8N1 = 2'b00,
    FMT_8E1 = 2'b01,
    FMT_8O1 = 2'b10,
    FMT_8N2 = 2'b11
  } psbp_fmt_t;
  localparam psbp_fmt_t FmtDefault = FMT_8N1;

  // telegram lengths
  localparam logic [3:0] ReqLen = 4'h3;
  localparam logic [3:0] RespShortLen = 4'h7;
  localparam logic [3:0] RespLongLen = 4'h9;

  // request header
  localparam logic [3:0] HdrPattern = 4'hC;
  localparam int HdrPatternLsb = 4;

  // commands
  localparam logic [7:0] CmdPos = 8'hF1;
  localparam logic [7:0] CmdStart = 8'hF4;
  localparam logic [7:0] CmdStop = 8'hF5;
  localparam logic [7:0] CmdSpeed = 8'hF6;
  localparam logic [7:0] CmdPosSpeed = 8'hF8;
  localparam logic [7:0] CmdMarker = 8'hFA;
  localparam logic [7:0] CmdDiag = 8'hFC;
  localparam logic [7:0] CmdSleep = 8'hFD;

  // status byte 0 bit positions
  localparam int S0Orient = 7;
  localparam int S0Ready = 6;
  localparam int S0SwTwo = 5;
  localparam int S0SwOne = 4;
  // status byte 1 bit positions
  localparam int S1Temp = 7;
  localparam int S1QualMsb = 6;
  localparam int S1Sleep = 4;
  localparam int S1Marker = 3;
  localparam int S1Diag = 2;
  localparam int S1Invalid = 1;
  localparam int S1Error = 0;

  // reading quality field
  localparam logic [1:0] QualAbove75 = 2'b00;
  localparam logic [1:0] Qual50To74 = 2'b01;
  localparam logic [1:0] Qual25To49 = 2'b10;
  localparam logic [1:0] QualBelow25 = 2'b11;

  // diagnostic codes, three ASCII characters
  localparam logic [23:0] DiagNone = 24'h45_3030;
  localparam logic [23:0] DiagCtrl = 24'h45_3031;
  localparam logic [23:0] DiagMotor = 24'h45_3032;
  localparam logic [23:0] DiagLaser = 24'h45_3033;
  localparam logic [23:0] DiagData = 24'h45_3035;

  localparam int FifoDepth = 16;
  localparam int FifoWidth = 8;

  function automatic logic parity8(input logic [7:0] b);
    return ^b;
  endfunction

  function automatic logic known_cmd(input logic [7:0] c);
    return c == CmdPos || c == CmdStart || c == CmdStop || c == CmdSpeed ||
           c == CmdPosSpeed || c == CmdMarker || c == CmdDiag || c == CmdSleep;
  endfunction

endpackage

/* File: design/psbp_link_if.sv */
/*
  Two-wire half-duplex serial link between host and device ends.
  Each end drives one output and an active-low output enable; the resolved bus level is computed here.
*/
`timescale 1ns/1ps
interface psbp_link_if;
  logic hostTx;
  logic hostTxEnN;
  logic devTx;
  logic devTxEnN;
  logic busLine;

  // idle line is high; enables are active low
  assign busLine = (!hostTxEnN ? hostTx : 1'b1) & (!devTxEnN ? devTx : 1'b1);

  modport host (output hostTx, output hostTxEnN, input busLine);
  modport device (output devTx, output devTxEnN, input busLine);
endinterface

/* File: design/psbp_fifo.sv */
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Single clock; full and empty derived from an occupancy count.
*/
`timescale 1ns/1ps
module psbp_fifo #(
  parameter int Width = 8,
  parameter int Depth = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int AW = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [AW-1:0] wrPtr_q, rdPtr_q;
  logic [AW:0] count_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = count_q != (AW+1)'(Depth);
  assign outValid = count_q != '0;
  assign outData = mem[rdPtr_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: design/psbp_host.sv */
/*
  Host end: sends a three-byte request on a user strobe and collects the seven- or nine-byte reply.
  Assumes one request outstanding at a time; replies not seen within the timeout are abandoned.
*/
`timescale 1ns/1ps
module psbp_host (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link
  psbp_link_if.host link,
  // serial configuration
  input wire logic [15:0] baudDiv,
  input wire psbp_pkg::psbp_fmt_t charFmt,
  // request
  input wire logic reqValid,
  input wire logic [3:0] reqAddr,
  input wire logic [7:0] reqCmd,
  output logic reqBusy,
  // reply
  output logic respValid,
  output logic [71:0] respData,
  output logic respCheckOk
);
  wire hasPar = charFmt == psbp_pkg::FMT_8E1 || charFmt == psbp_pkg::FMT_8O1;
  wire [15:0] divEnd = baudDiv - 16'h0001; // R22

  // request: header pattern, address, command, XOR check byte
  wire [7:0] hdr = {psbp_pkg::HdrPattern, reqAddr}; // R02 R03
  wire [23:0] reqMsg = {hdr, reqCmd, hdr ^ reqCmd}; // R07 R01
  wire expectLong = reqCmd == psbp_pkg::CmdPosSpeed;
  wire expectNone = reqCmd == psbp_pkg::CmdStart || reqCmd == psbp_pkg::CmdStop || reqCmd == psbp_pkg::CmdSleep;

  logic [23:0] txMsg_q;
  logic [1:0] txBytes_q;
  logic [10:0] txSh_q;
  logic [3:0] txLeft_q;
  logic [15:0] txCnt_q;
  logic txOut_q, txEnN_q;
  logic [3:0] want_q;
  logic [3:0] got_q;
  logic [23:0] wait_q;
  wire [7:0] nb = txMsg_q[23:16];
  wire txPar = psbp_pkg::parity8(nb) ^ (charFmt == psbp_pkg::FMT_8O1);
  wire [10:0] txFrame = hasPar ? {1'b1, txPar, nb, 1'b0} : {2'b11, nb, 1'b0}; // R21

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txMsg_q <= 24'h0;
      txBytes_q <= 2'd0;
      txSh_q <= 11'h7FF;
      txLeft_q <= 4'h0;
      txCnt_q <= 16'h0000;
      txOut_q <= 1'b1;
      txEnN_q <= 1'b1;
      reqBusy <= 1'b0;
      want_q <= 4'h0;
      wait_q <= 24'h0;
    end else begin
      if (!reqBusy && reqValid) begin
        reqBusy <= 1'b1;
        txMsg_q <= reqMsg;
        txBytes_q <= 2'd3;
        want_q <= expectNone ? 4'h0 : (expectLong ? psbp_pkg::RespLongLen : psbp_pkg::RespShortLen);
        wait_q <= 24'h0;
      end else if (txLeft_q != 4'h0) begin
        txOut_q <= txSh_q[0];
        txEnN_q <= 1'b0;
        if (txCnt_q == divEnd) begin
          txCnt_q <= 16'h0000;
          txSh_q <= {1'b1, txSh_q[10:1]};
          txLeft_q <= txLeft_q - 4'h1;
        end else begin
          txCnt_q <= txCnt_q + 16'h0001;
        end
      end else if (txBytes_q != 2'd0) begin
        txSh_q <= txFrame;
        txLeft_q <= charFmt == psbp_pkg::FMT_8N1 ? 4'd10 : 4'd11;
        txCnt_q <= 16'h0000;
        txMsg_q <= {txMsg_q[15:0], 8'h00};
        txBytes_q <= txBytes_q - 2'd1;
      end else begin
        txOut_q <= 1'b1;
        txEnN_q <= 1'b1;
        wait_q <= wait_q + 24'h1;
        // done when reply complete, none expected, or a long silence (dropped request)
        if (reqBusy && (got_q == want_q || wait_q == {baudDiv, 8'h00})) begin
          reqBusy <= 1'b0;
        end
      end
    end
  end
  assign link.hostTx = txOut_q;
  assign link.hostTxEnN = txEnN_q;

  // receiver
  logic rxS1_q, rxS2_q;
  logic rxAct_q;
  logic [15:0] rxCnt_q;
  logic [3:0] rxBit_q;
  logic [9:0] rxSh_q;
  logic [7:0] xor_q;
  wire [3:0] rxBits = hasPar ? 4'd10 : 4'd9;
  wire rxMid = rxCnt_q == {1'b0, baudDiv[15:1]};
  wire [7:0] rxByte = hasPar ? rxSh_q[8:1] : rxSh_q[9:2];
  wire rxDone = rxAct_q && rxMid && rxBit_q == rxBits;
  wire lastIn = rxDone && got_q == want_q - 4'h1;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
      rxAct_q <= 1'b0;
      rxCnt_q <= 16'h0000;
      rxBit_q <= 4'h0;
      rxSh_q <= 10'h000;
      got_q <= 4'h0;
      xor_q <= 8'h00;
      respValid <= 1'b0;
      respData <= 72'h0;
      respCheckOk <= 1'b0;
    end else begin
      rxS1_q <= link.busLine;
      rxS2_q <= rxS1_q;
      respValid <= 1'b0;
      if (!reqBusy || txBytes_q != 2'd0) begin
        got_q <= 4'h0;
        xor_q <= 8'h00;
        rxAct_q <= 1'b0;
      end else if (!rxAct_q) begin
        if (!rxS2_q && txEnN_q) begin
          rxAct_q <= 1'b1;
          rxCnt_q <= 16'h0000;
          rxBit_q <= 4'h0;
        end
      end else begin
        rxCnt_q <= rxCnt_q == divEnd ? 16'h0000 : rxCnt_q + 16'h0001;
        if (rxMid) begin
          rxSh_q <= {rxS2_q, rxSh_q[9:1]};
          rxBit_q <= rxBit_q + 4'h1;
        end
        if (rxDone) begin
          rxAct_q <= 1'b0;
          got_q <= got_q + 4'h1;
          xor_q <= xor_q ^ rxByte; // R20
          respData <= {respData[63:0], rxByte}; // R11 R12
          if (lastIn) begin
            respValid <= 1'b1;
            respCheckOk <= xor_q == rxByte; // R20
          end
        end
      end
    end
  end
endmodule

/* File: verification/psbp_checker.sv */
/*
  Checker for the serial link that joins host and device ends.
  Assumes BitClks equals the baudDiv given to both ends.
*/
`timescale 1ns/1ps
module psbp_checker #(
  parameter int BitClks = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link wires
  input wire logic hostTx,
  input wire logic hostTxEnN,
  input wire logic devTx,
  input wire logic devTxEnN,
  input wire logic busLine
);
  localparam int GapMax = 4 * BitClks;
  logic [7:0] sinceHost_q;
  logic [7:0] sinceHost_d;
  // saturates so a long idle never wraps
  assign sinceHost_d = !hostTxEnN ? 8'h00 : (sinceHost_q == 8'hFF ? sinceHost_q : sinceHost_q + 8'h01);
  always_ff @(posedge mclk) begin
    if (!resetn) sinceHost_q <= 8'hFF;
    else sinceHost_q <= sinceHost_d;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence lowRun;
    (!busLine) [*8];
  endsequence
  sequence highRun;
    busLine [*8];
  endsequence
  sequence hostStart;
    (!hostTx) [*8];
  endsequence

  reset_idle_a: assert property ($rose(resetn) |-> hostTxEnN && devTxEnN && hostTx && devTx)
    else $error("link not idle after reset");
  bit_low_a: assert property ($fell(busLine) |-> lowRun)
    else $error("low bit too short");
  bit_high_a: assert property ($rose(busLine) |-> highRun)
    else $error("high bit too short");
  host_start_a: assert property ($fell(hostTxEnN) |-> hostStart)
    else $error("host frame without start bit");
  host_stop_a: assert property ($rose(hostTxEnN) |-> $past(hostTx))
    else $error("host released before stop level");
  dev_start_a: assert property ($fell(devTxEnN) |-> ##[0:2] !devTx)
    else $error("device frame without start bit");
  dev_stop_a: assert property ($rose(devTxEnN) |-> $past(devTx))
    else $error("device released before stop level");
  reply_gap_a: assert property ($fell(devTxEnN) |-> sinceHost_q <= GapMax)
    else $error("device drove without a request");
endmodule

/* File: verification/psbp_bench.sv */
/*
  Self-checking bench: host and device ends joined by the link interface.
  Assumes both ends share one baud divider and character format.
*/
`timescale 1ns/1ps
module psbp_bench;
  localparam int BitClks = 16;
  logic mclk;
  logic resetn;
  logic [15:0] baudDiv;
  psbp_pkg::psbp_fmt_t charFmt;
  logic [3:0] stationAddr;
  logic [31:0] measured_value;
  logic [31:0] speedLong;
  logic [15:0] speed_value;
  logic [23:0] markerCode;
  logic [23:0] diagCode;
  logic [6:0] qualityPercent;
  logic markerValid, diagValid, tape_orientation, deviceReady;
  logic switch_line_one, switch_line_two, temp_warning, measureInvalid, deviceError;
  logic positioning, sleepActive, reqDropped;
  logic reqValid, reqBusy, respValid, respCheckOk;
  logic [3:0] reqAddr;
  logic [7:0] reqCmd;
  logic [71:0] respData;
  logic gotResp, dropped, expSleep;
  logic [23:0] codes [4];
  int error_cnt;
  int cmp_count;

  psbp_link_if link();
  psbp_device psbp_device_i (.mclk(mclk), .resetn(resetn), .link(link), .baudDiv(baudDiv),
    .charFmt(charFmt), .stationAddr(stationAddr), .measured_value(measured_value), .speedLong(speedLong),
    .speed_value(speed_value), .markerCode(markerCode), .markerValid(markerValid), .diagCode(diagCode),
    .diagValid(diagValid), .tape_orientation(tape_orientation), .deviceReady(deviceReady),
    .switch_line_one(switch_line_one), .switch_line_two(switch_line_two), .temp_warning(temp_warning),
    .qualityPercent(qualityPercent), .measureInvalid(measureInvalid), .deviceError(deviceError),
    .positioning(positioning), .sleepActive(sleepActive), .reqDropped(reqDropped));
  psbp_host psbp_host_i (.mclk(mclk), .resetn(resetn), .link(link), .baudDiv(baudDiv), .charFmt(charFmt),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqCmd(reqCmd), .reqBusy(reqBusy), .respValid(respValid),
    .respData(respData), .respCheckOk(respCheckOk));
  psbp_checker #(.BitClks(BitClks)) psbp_checker_i (.mclk(mclk), .resetn(resetn), .hostTx(link.hostTx),
    .hostTxEnN(link.hostTxEnN), .devTx(link.devTx), .devTxEnN(link.devTxEnN), .busLine(link.busLine));

  always #4 mclk = ~mclk;

  // pulses are caught here so the waiting task cannot miss them
  always @(posedge mclk) begin
    if (respValid === 1'b1) gotResp <= 1'b1;
    if (reqDropped === 1'b1) dropped <= 1'b1;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t flag %b want %b", $time, g, e);
    end
  endtask

  task automatic chk72(input logic [71:0] g, input logic [71:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t data %h want %h", $time, g, e);
    end
  endtask

  function automatic logic [71:0] expResp(input logic [7:0] c);
    logic [1:0] q;
    logic [15:0] s;
    logic [31:0] d;
    logic [63:0] p;
    logic [7:0] x;
    int n;
    q = qualityPercent >= 7'h4B ? psbp_pkg::QualAbove75 : qualityPercent >= 7'h32 ? psbp_pkg::Qual50To74 :
        qualityPercent >= 7'h19 ? psbp_pkg::Qual25To49 : psbp_pkg::QualBelow25;
    s = {tape_orientation, deviceReady, switch_line_two, switch_line_one, stationAddr,
         temp_warning, q, expSleep, markerValid, diagValid, measureInvalid, deviceError};
    case (c)
      psbp_pkg::CmdSpeed: d = speedLong;
      psbp_pkg::CmdMarker: d = {8'h00, markerCode};
      psbp_pkg::CmdDiag: d = {8'h00, diagValid ? diagCode : psbp_pkg::DiagNone};
      default: d = measured_value;
    endcase
    n = c == psbp_pkg::CmdPosSpeed ? 8 : 6;
    p = n == 8 ? {s, measured_value, speed_value} : {16'h0000, s, d};
    x = 8'h00;
    for (int i = 0; i < n; i++) x ^= p[8*i +: 8];
    return {p, x};
  endfunction

  // entered only while reqBusy is low
  task automatic req(input logic [3:0] a, input logic [7:0] c);
    int n;
    gotResp = 1'b0;
    dropped = 1'b0;
    reqAddr = a;
    reqCmd = c;
    reqValid = 1'b1;
    tick();
    reqValid = 1'b0;
    n = 0;
    while (reqBusy !== 1'b0 && n < 9000) begin
      tick();
      n++;
    end
    if (n >= 9000) begin
      error_cnt++;
      $display("BAD %0t host stayed busy", $time);
    end
    repeat (20) tick();
  endtask

  task automatic ask(input logic [7:0] c);
    req(stationAddr, c);
    chk1(gotResp, 1'b1);
    chk1(respCheckOk, 1'b1);
    chk72(c == psbp_pkg::CmdPosSpeed ? respData : {16'h0000, respData[55:0]}, expResp(c));
  endtask

  // decodes the first request byte straight off the wire
  task automatic snoop();
    logic [7:0] b;
    @(negedge link.busLine);
    repeat (BitClks / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BitClks) @(posedge mclk);
      b[i] = link.busLine;
    end
    repeat (BitClks) @(posedge mclk);
    chk72({64'h0, b}, {64'h0, 8'hC0 | stationAddr});
    chk1(link.busLine, 1'b1);
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    baudDiv = 16'(BitClks);
    charFmt = psbp_pkg::FMT_8N1;
    stationAddr = 4'h5;
    measured_value = 32'h1234_5678;
    speedLong = 32'h0000_0ABC;
    speed_value = 16'hBEEF;
    markerCode = 24'h41_3031;
    diagCode = psbp_pkg::DiagNone;
    {markerValid, diagValid, tape_orientation, deviceReady} = 4'h0B;
    {switch_line_one, switch_line_two, temp_warning, measureInvalid, deviceError} = 5'h15;
    qualityPercent = 7'h1E;
    {reqValid, reqAddr, reqCmd, expSleep} = 14'h0000;
    error_cnt = 0;
    cmp_count = 0;
    codes = '{psbp_pkg::DiagCtrl, psbp_pkg::DiagMotor, psbp_pkg::DiagLaser, psbp_pkg::DiagData};
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    chk1(link.busLine, 1'b1);
    fork
      ask(psbp_pkg::CmdPos);
      snoop();
    join
    for (int f = 1; f < 4; f++) begin
      charFmt = psbp_pkg::psbp_fmt_t'(f);
      ask(psbp_pkg::CmdPos);
    end
    charFmt = psbp_pkg::FMT_8N1;
    ask(psbp_pkg::CmdSpeed);
    ask(psbp_pkg::CmdPosSpeed);
    ask(psbp_pkg::CmdMarker);
    ask(psbp_pkg::CmdDiag);
    for (int k = 0; k < 4; k++) begin
      diagValid = 1'b1;
      diagCode = codes[k];
      ask(psbp_pkg::CmdDiag);
    end
    qualityPercent = 7'h50;
    {temp_warning, tape_orientation, switch_line_two} = 3'h3;
    ask(psbp_pkg::CmdPos);
    req(stationAddr, psbp_pkg::CmdStart);
    chk1(positioning, 1'b1);
    chk1(gotResp, 1'b0);
    req(stationAddr, psbp_pkg::CmdSleep);
    expSleep = 1'b1;
    chk1(sleepActive, 1'b1);
    chk1(positioning, 1'b0);
    ask(psbp_pkg::CmdPos);
    req(stationAddr, psbp_pkg::CmdStart);
    expSleep = 1'b0;
    req(stationAddr, psbp_pkg::CmdStop);
    chk1(positioning, 1'b0);
    chk1(sleepActive, 1'b0);
    req(4'h6, psbp_pkg::CmdPos);
    chk1(gotResp, 1'b0);
    chk1(dropped, 1'b1);
    req(stationAddr, 8'hF2);
    chk1(gotResp, 1'b0);
    chk1(dropped, 1'b1);
    // byte counting must still be aligned after refusals
    ask(psbp_pkg::CmdPos);
    end_of_test();
  end
endmodule
